// >>> design/i2cm_master.sv
// Purpose: i2c master transmit/receive sequencing with register port
// Assumes: open-drain pins, enable high pulls the line low
// Notes:   slave operation is not built; lost arbitration just releases
//
// Chosen here: the strobed register port.
`default_nettype none

module i2cm_master (
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       t1_overflow_i,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o
);
    // ========================================================
    // declarations
    logic       interface_enable;
    logic       begin_request;
    logic       end_condition_request;
    logic       event_flag;
    logic       ack_enable;
    logic       rate_source_select;
    logic [7:0] scl_high_period;
    logic [7:0] scl_low_period;
    logic [7:0] byte_buffer;
    logic [7:0] state_code;
    i2cm_pkg::i2cm_state_e state;
    logic [3:0] bit_cnt;
    logic       rx_mode;
    logic       first_byte;
    logic       repeat_start;
    logic       sda_low;
    logic       scl_s1, scl_s2, scl_prev;
    logic       sda_s1, sda_s2, sda_prev;
    logic       bus_busy;
    logic       start_det, stop_det;
    logic       gen_run, gen_park, scl_low, end_high, fell;
    logic       tx_now, lost;
    logic       evt_set;
    logic [7:0] evt_code;
    logic       wr_ctl, wr_buf;

    assign wr_ctl = reg_wr_i && reg_addr_i == i2cm_pkg::ADDR_CONTROL;
    assign wr_buf = reg_wr_i && reg_addr_i == i2cm_pkg::ADDR_BUFFER;

    // ========================================================
    // pin synchronisers and bus condition detection
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            {scl_s1, scl_s2, scl_prev} <= 3'h7;
            {sda_s1, sda_s2, sda_prev} <= 3'h7;
        end else begin
            scl_s1   <= scl_i;
            scl_s2   <= scl_s1;
            scl_prev <= scl_s2;
            sda_s1   <= sda_i;
            sda_s2   <= sda_s1;
            sda_prev <= sda_s2;
        end
    end

    assign start_det = scl_s2 && scl_prev && sda_prev && !sda_s2;
    assign stop_det  = scl_s2 && scl_prev && !sda_prev && sda_s2;

    // busy from any start until the next stop, whoever drives them
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !interface_enable)
            bus_busy <= 1'b0;
        else if (start_det)
            bus_busy <= 1'b1;
        else if (stop_det)
            bus_busy <= 1'b0;
    end

    // ========================================================
    // clock generator
    assign gen_run  = interface_enable && state != i2cm_pkg::M_IDLE;
    assign gen_park = state == i2cm_pkg::M_STOP || state == i2cm_pkg::M_RSTART;

    i2cm_scl_gen u_scl_gen (
        .sys_clk_i     (sys_clk_i),
        .reset_i       (reset_i),
        .run_i         (gen_run),
        .stall_i       (event_flag),
        .park_i        (gen_park),
        .src_i         (rate_source_select),
        .t1_ovf_i      (t1_overflow_i),
        .high_period_i (scl_high_period),
        .low_period_i  (scl_low_period),
        .scl_low_o     (scl_low),
        .end_high_o    (end_high),
        .fell_o        (fell)
    );

    // open drain: the line level is only ever pulled low
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_o = scl_low;
    assign sda_oe_o = sda_low;

    // ========================================================
    // event reporting
    assign tx_now = first_byte || !rx_mode;
    // a released data bit read back low means another master won
    assign lost = tx_now && bit_cnt != i2cm_pkg::ACK_SLOT && !sda_low && !sda_s2;

    always_comb begin
        evt_set  = 1'b0;
        evt_code = i2cm_pkg::ST_NONE;
        if (state == i2cm_pkg::M_START && end_high) begin
            evt_set  = 1'b1;
            evt_code = repeat_start ? i2cm_pkg::ST_RSTART : i2cm_pkg::ST_START;
        end else if (state == i2cm_pkg::M_XFER && end_high) begin
            if (lost) begin
                evt_set  = 1'b1;
                evt_code = i2cm_pkg::ST_ARB_LOST;
            end else if (bit_cnt == i2cm_pkg::ACK_SLOT) begin
                evt_set = 1'b1;
                case ({first_byte, rx_mode})
                    2'b10:   evt_code = sda_s2 ? i2cm_pkg::ST_AW_NACK : i2cm_pkg::ST_AW_ACK;
                    2'b11:   evt_code = sda_s2 ? i2cm_pkg::ST_AR_NACK : i2cm_pkg::ST_AR_ACK;
                    2'b00:   evt_code = sda_s2 ? i2cm_pkg::ST_DW_NACK : i2cm_pkg::ST_DW_ACK;
                    default: evt_code = sda_s2 ? i2cm_pkg::ST_DR_NACK : i2cm_pkg::ST_DR_ACK;
                endcase
            end
        end
    end

    // ========================================================
    // control register: the hardware set of the event flag wins
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            interface_enable      <= 1'b0;
            begin_request         <= 1'b0;
            end_condition_request <= 1'b0;
            event_flag            <= 1'b0;
            ack_enable            <= 1'b0;
            rate_source_select    <= 1'b0;
        end else begin
            if (wr_ctl) begin
                interface_enable   <= reg_wdata_i[i2cm_pkg::CTL_ENABLE];
                begin_request      <= reg_wdata_i[i2cm_pkg::CTL_BEGIN];
                ack_enable         <= reg_wdata_i[i2cm_pkg::CTL_ACK];
                rate_source_select <= reg_wdata_i[i2cm_pkg::CTL_SRC];
            end
            // software can only clear the flag
            if (evt_set)
                event_flag <= 1'b1;
            else if (wr_ctl && !reg_wdata_i[i2cm_pkg::CTL_EVENT])
                event_flag <= 1'b0;
            // a stop seen on the bus retires the end request
            if (wr_ctl && reg_wdata_i[i2cm_pkg::CTL_END])
                end_condition_request <= 1'b1;
            else if (stop_det || !interface_enable || (wr_ctl && !reg_wdata_i[i2cm_pkg::CTL_END]))
                end_condition_request <= 1'b0;
        end
    end

    // state code follows the flag; f8h from one cycle after the flag clears
    always_ff @(posedge sys_clk_i) begin
        if (reset_i)
            state_code <= i2cm_pkg::ST_NONE;
        else if (evt_set)
            state_code <= evt_code;
        else if (!event_flag)
            state_code <= i2cm_pkg::ST_NONE;
    end

    // period registers and byte buffer, which doubles as shifter
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            scl_high_period <= i2cm_pkg::RST_PERIOD;
            scl_low_period  <= i2cm_pkg::RST_PERIOD;
            byte_buffer     <= 8'h00;
        end else begin
            if (reg_wr_i && reg_addr_i == i2cm_pkg::ADDR_SCL_HIGH)
                scl_high_period <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == i2cm_pkg::ADDR_SCL_LOW)
                scl_low_period <= reg_wdata_i;
            if (wr_buf)
                byte_buffer <= reg_wdata_i;
            else if (state == i2cm_pkg::M_XFER && end_high && bit_cnt != i2cm_pkg::ACK_SLOT)
                byte_buffer <= {byte_buffer[6:0], sda_s2};    // msb first
        end
    end

    // ========================================================
    // sequencer
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !interface_enable) begin
            state        <= i2cm_pkg::M_IDLE;
            sda_low      <= 1'b0;
            bit_cnt      <= 4'h0;
            rx_mode      <= 1'b0;
            first_byte   <= 1'b0;
            repeat_start <= 1'b0;
        end else begin
            case (state)
                i2cm_pkg::M_IDLE: begin
                    if (begin_request && !bus_busy && !event_flag) begin
                        state        <= i2cm_pkg::M_START;
                        sda_low      <= 1'b1;
                        repeat_start <= 1'b0;
                    end
                end
                i2cm_pkg::M_START: begin
                    if (end_high) begin
                        state      <= i2cm_pkg::M_WAIT;
                        first_byte <= 1'b1;
                    end
                end
                i2cm_pkg::M_WAIT: begin
                    // nothing moves until software clears the flag
                    if (!event_flag) begin
                        if (end_condition_request) begin
                            state   <= i2cm_pkg::M_STOP;
                            sda_low <= 1'b1;
                        end else if (begin_request && !first_byte) begin
                            state   <= i2cm_pkg::M_RSTART;
                            sda_low <= 1'b0;
                        end else begin
                            state   <= i2cm_pkg::M_XFER;
                            bit_cnt <= 4'h0;
                            if (first_byte)
                                rx_mode <= byte_buffer[0];
                            sda_low <= tx_now && !byte_buffer[7];
                        end
                    end
                end
                i2cm_pkg::M_XFER: begin
                    if (end_high) begin
                        if (lost) begin
                            // never turns slave here, so no slave codes
                            state   <= i2cm_pkg::M_IDLE;
                            sda_low <= 1'b0;
                        end else if (bit_cnt == i2cm_pkg::ACK_SLOT) begin
                            state      <= i2cm_pkg::M_WAIT;
                            first_byte <= 1'b0;
                        end else
                            bit_cnt <= bit_cnt + 4'h1;
                    end else if (fell) begin
                        if (bit_cnt == i2cm_pkg::ACK_SLOT)
                            sda_low <= !tx_now && ack_enable;
                        else
                            sda_low <= tx_now && !byte_buffer[7];
                    end
                end
                i2cm_pkg::M_STOP: begin
                    if (end_high) begin
                        state   <= i2cm_pkg::M_IDLE;
                        sda_low <= 1'b0;    // sda rises while scl high
                    end
                end
                i2cm_pkg::M_RSTART: begin
                    if (end_high) begin
                        state        <= i2cm_pkg::M_START;
                        sda_low      <= 1'b1;
                        repeat_start <= 1'b1;
                    end
                end
                default: state <= i2cm_pkg::M_IDLE;
            endcase
        end
    end

    // ========================================================
    // register read port, data one cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (reset_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i) begin
            case (reg_addr_i)
                i2cm_pkg::ADDR_CONTROL: reg_rdata_o <= {1'b0, interface_enable, begin_request,
                    end_condition_request, event_flag, ack_enable, 1'b0, rate_source_select};
                // a cleared flag reads f8h at once, even in the cycle the clear lands
                i2cm_pkg::ADDR_STATE:    reg_rdata_o <= (event_flag ? state_code : i2cm_pkg::ST_NONE)
                    & i2cm_pkg::CODE_LOW_MASK;
                i2cm_pkg::ADDR_BUFFER:   reg_rdata_o <= byte_buffer;
                i2cm_pkg::ADDR_SCL_HIGH: reg_rdata_o <= scl_high_period;
                i2cm_pkg::ADDR_SCL_LOW:  reg_rdata_o <= scl_low_period;
                default:                 reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ========================================================
    // checks
    property p_start_code;
        @(posedge sys_clk_i) disable iff (reset_i)
        state == i2cm_pkg::M_START && end_high && interface_enable
        |=> event_flag && (state_code == i2cm_pkg::ST_START || state_code == i2cm_pkg::ST_RSTART);
    endproperty
    a_start_code: assert property (p_start_code) else $error("no 08h after start");

    property p_stall;
        @(posedge sys_clk_i) disable iff (reset_i)
        (state == i2cm_pkg::M_WAIT && event_flag && interface_enable)[*3] |-> scl_oe_o;
    endproperty
    a_stall: assert property (p_stall) else $error("scl not held low while flag set");

    property p_idle_code;
        @(posedge sys_clk_i) disable iff (reset_i)
        reg_rd_i && reg_addr_i == i2cm_pkg::ADDR_STATE && !event_flag && !evt_set
        |=> reg_rdata_o == i2cm_pkg::ST_NONE;
    endproperty
    a_idle_code: assert property (p_idle_code) else $error("idle state code not f8h");

    property p_low_bits;
        @(posedge sys_clk_i) disable iff (reset_i)
        $past(reg_rd_i) && $past(reg_addr_i) == i2cm_pkg::ADDR_STATE |-> reg_rdata_o[2:0] == 3'h0;
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("state code low bits set");

    property p_disabled;
        @(posedge sys_clk_i) disable iff (reset_i)
        !interface_enable |=> !scl_oe_o && !sda_oe_o;
    endproperty
    a_disabled: assert property (p_disabled) else $error("lines driven while disabled");

    property p_stop_clear;
        @(posedge sys_clk_i) disable iff (reset_i)
        stop_det && !wr_ctl |=> !end_condition_request;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("end request kept after stop");

    property p_ack_event;
        @(posedge sys_clk_i) disable iff (reset_i)
        state == i2cm_pkg::M_XFER && end_high && !lost && bit_cnt == i2cm_pkg::ACK_SLOT
        && interface_enable |=> state == i2cm_pkg::M_WAIT && event_flag;
    endproperty
    a_ack_event: assert property (p_ack_event) else $error("no event after ack slot");

    property p_begin;
        @(posedge sys_clk_i) disable iff (reset_i)
        state == i2cm_pkg::M_IDLE && interface_enable && begin_request && !bus_busy
        && !event_flag |=> state == i2cm_pkg::M_START && sda_oe_o && !scl_oe_o;
    endproperty
    a_begin: assert property (p_begin) else $error("start not issued on free bus");

    property p_direction;
        @(posedge sys_clk_i) disable iff (reset_i)
        state == i2cm_pkg::M_WAIT && first_byte && !event_flag && !end_condition_request
        && interface_enable |=> rx_mode == $past(byte_buffer[0]);
    endproperty
    a_direction: assert property (p_direction) else $error("direction bit not taken");
endmodule : i2cm_master

`default_nettype wire

// >>> design/i2cm_pkg.sv
// Purpose: shared constants for the i2c master clock and mode block
// Assumes: one 125 MHz clock, register port with 8-bit addresses
// Notes:   state codes keep their three low bits at zero
//
// Operation
// - scl high/low follow the two period registers
// - bit rate is clock over twice period sum
// - unequal periods give uneven scl duty
// - source select picks counters or timer overflow
// - ack enable low keeps device out of slave
// - first byte is address plus direction bit
// - eight bits then one ack bit per byte
// - begin request issues start once bus free
// - after start, event flag and code 08h
// - transfer stalls while event flag stays set
// - address write phase reports 18h, 20h, 38h
// - slave codes 68h, 78h, b0h may follow; not built here, lost arbitration returns to idle
// - master receive starts like transmit, read bit
// - address read phase reports 40h, 48h, 38h
// - repeated start may switch to transmit
// - low state bits zero, f8h when idle
// - end request sends stop, clears on stop
// - begin request while busy gives repeated start
`default_nettype none

package i2cm_pkg;
    // ========================================================
    // register offsets
    localparam logic [7:0] ADDR_CONTROL = 8'hd8;
    localparam logic [7:0] ADDR_STATE   = 8'hd9;
    localparam logic [7:0] ADDR_BUFFER  = 8'hda;
    localparam logic [7:0] ADDR_SCL_LOW = 8'hdc;
    localparam logic [7:0] ADDR_SCL_HIGH = 8'hdd;

    // ========================================================
    // control field positions and reset values
    localparam int CTL_ENABLE = 6;
    localparam int CTL_BEGIN  = 5;
    localparam int CTL_END    = 4;
    localparam int CTL_EVENT  = 3;
    localparam int CTL_ACK    = 2;
    localparam int CTL_SRC    = 0;
    localparam logic [7:0] RST_PERIOD = 8'h00;
    localparam logic [7:0] CODE_LOW_MASK = 8'hf8;

    // ========================================================
    // state codes
    localparam logic [7:0] ST_START    = 8'h08;
    localparam logic [7:0] ST_RSTART   = 8'h10;
    localparam logic [7:0] ST_AW_ACK   = 8'h18;
    localparam logic [7:0] ST_AW_NACK  = 8'h20;
    localparam logic [7:0] ST_DW_ACK   = 8'h28;
    localparam logic [7:0] ST_DW_NACK  = 8'h30;
    localparam logic [7:0] ST_ARB_LOST = 8'h38;
    localparam logic [7:0] ST_AR_ACK   = 8'h40;
    localparam logic [7:0] ST_AR_NACK  = 8'h48;
    localparam logic [7:0] ST_DR_ACK   = 8'h50;
    localparam logic [7:0] ST_DR_NACK  = 8'h58;
    localparam logic [7:0] ST_NONE     = 8'hf8;

    // ========================================================
    // timing and framing
    localparam int         PCLK_DIV = 2;       // sys cycles per period unit
    localparam logic [3:0] ACK_SLOT = 4'h8;    // bit index of the ack slot

    typedef enum logic [2:0] {
        M_IDLE   = 3'b000,
        M_START  = 3'b001,
        M_WAIT   = 3'b011,
        M_XFER   = 3'b010,
        M_STOP   = 3'b110,
        M_RSTART = 3'b111
    } i2cm_state_e;
endpackage : i2cm_pkg

`default_nettype wire

// >>> design/i2cm_scl_gen.sv
// Purpose: serial clock generator with high and low period counters
// Assumes: period units are PCLK_DIV system clocks
// Notes:   no clock stretching, so the rate stays exact
`default_nettype none

module i2cm_scl_gen #(
    parameter int PCLK_DIV = i2cm_pkg::PCLK_DIV
) (
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic       run_i,
    input  wire logic       stall_i,
    input  wire logic       park_i,
    input  wire logic       src_i,
    input  wire logic       t1_ovf_i,
    input  wire logic [7:0] high_period_i,
    input  wire logic [7:0] low_period_i,
    output logic            scl_low_o,
    output logic            end_high_o,
    output logic            fell_o
);
    // ========================================================
    // period unit divider
    logic [7:0] div_cnt;
    logic       pclk_en;
    logic       tick;
    logic [7:0] cnt;

    // a zero period would stop the clock, so it counts as one
    function automatic logic [7:0] load_of(input logic src, input logic [7:0] v);
        load_of = (src || v == 8'h00) ? 8'h01 : v;
    endfunction : load_of

    assign pclk_en = (div_cnt == 8'(PCLK_DIV - 1));
    assign tick    = src_i ? t1_ovf_i : pclk_en;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !run_i || pclk_en)
            div_cnt <= 8'h00;
        else
            div_cnt <= div_cnt + 8'h01;
    end

    // ========================================================
    // phase counter: high first, low may be stalled, high may park
    assign end_high_o = run_i && !scl_low_o && tick && cnt <= 8'h01;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !run_i) begin
            scl_low_o <= 1'b0;
            cnt       <= load_of(src_i, high_period_i);
        end else if (tick) begin
            if (scl_low_o) begin
                if (!stall_i) begin
                    if (cnt <= 8'h01) begin
                        scl_low_o <= 1'b0;
                        cnt       <= load_of(src_i, high_period_i);
                    end else
                        cnt <= cnt - 8'h01;
                end
            end else if (cnt <= 8'h01) begin
                if (park_i)
                    cnt <= load_of(src_i, high_period_i);
                else begin
                    scl_low_o <= 1'b1;
                    cnt       <= load_of(src_i, low_period_i);
                end
            end else
                cnt <= cnt - 8'h01;
        end
    end

    // data may change only once scl is already low
    always_ff @(posedge sys_clk_i) begin
        if (reset_i)
            fell_o <= 1'b0;
        else
            fell_o <= end_high_o && !park_i;
    end

    // ========================================================
    // checks
    logic [9:0] span;
    logic       full_high;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !run_i || scl_low_o != $past(scl_low_o))
            span <= 10'h001;
        else
            span <= span + 10'h001;
    end
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !run_i || park_i)
            full_high <= 1'b0;
        else if ($fell(scl_low_o))
            full_high <= 1'b1;
        else if ($rose(scl_low_o))
            full_high <= 1'b0;
    end

    property p_high_len;
        @(posedge sys_clk_i) disable iff (reset_i)
        $rose(scl_low_o) && run_i && !src_i && full_high && $stable(high_period_i)
        |-> span == 10'(PCLK_DIV * load_of(1'b0, high_period_i));
    endproperty
    a_high_len: assert property (p_high_len) else $error("scl high period length wrong");
endmodule : i2cm_scl_gen

`default_nettype wire

// >>> sim/i2c_master_clock_and_modes_test.sv
// Purpose: self-checking bench for the i2c master block
// Assumes: open-drain lines pulled up, slave model at address 2a
// Notes:   small period values keep every frame short
`default_nettype none
module i2c_master_clock_and_modes_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic w; logic [7:0] e;} i2cm_row_s;
    logic       sys_clk = 1'b0, reset = 1'b1, we = 1'b0, re = 1'b0, ovf = 1'b0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata, q, hi, lo;
    logic       scl_oe, sda_oe, slv_oe;
    int         fails = 0, cmp_count = 0, cyc = 0, n;
    // reset values first, then writes; periods above three units
    i2cm_row_s  rows [9] = '{'{8'hd8, 8'h00, 1'b0, 8'h00}, '{8'hdc, 8'h00, 1'b0, 8'h00},
        '{8'hdd, 8'h00, 1'b0, 8'h00}, '{8'hd9, 8'h00, 1'b0, 8'hf8}, '{8'hdd, 8'h04, 1'b1, 8'h04},
        '{8'hdc, 8'h06, 1'b1, 8'h06}, '{8'hd9, 8'h55, 1'b1, 8'hf8}, '{8'he0, 8'h33, 1'b1, 8'h00},
        '{8'hd8, 8'h44, 1'b1, 8'h44}};
    wire logic  scl_line = !scl_oe;
    wire logic  sda_line = !(sda_oe | slv_oe);
    always #4 sys_clk = ~sys_clk;
    i2cm_master dut (.sys_clk_i(sys_clk), .reset_i(reset), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rdata), .t1_overflow_i(ovf),
        .scl_i(scl_line), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_line), .sda_o(),
        .sda_oe_o(sda_oe));
    i2cm_slave_model slv (.scl_i(scl_line), .sda_i(sda_line), .sda_oe_o(slv_oe));
    // ========================================
    // bus cycles and comparisons
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge sys_clk);
        we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        @(posedge sys_clk);
        addr <= a;
        re <= 1'b1;
        @(posedge sys_clk);
        re <= 1'b0;
        #1 r = rdata;
    endtask : rd
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // poll the event flag, bounded, then compare the state code
    task automatic wait_ev(input logic [7:0] code);
        n = 0;
        q = 8'h00;
        while (q[3] !== 1'b1 && n < 500) begin
            rd(8'hd8, q);
            n++;
        end
        rd(8'hd9, q);
        chk(q, code);
    endtask : wait_ev
    task automatic send(input logic [7:0] b, input logic [7:0] code);
        wr(8'hd8, 8'h60);
        wait_ev(8'h10);
        wr(8'hda, b);
        wr(8'hd8, 8'h40);
        wait_ev(code);
    endtask : send
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // hang guard: whole run needs well under this many cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a, q);
            chk(q, rows[i].e);
        end
        $display("registers done");
        wr(8'hd8, 8'h60);
        wait_ev(8'h08);
        wr(8'hda, 8'h54);
        wr(8'hd8, 8'h40);
        hi = 8'h00;
        lo = 8'h00;
        while (scl_oe !== 1'b0) @(posedge sys_clk);
        while (scl_oe === 1'b0) begin
            @(posedge sys_clk);
            hi++;
        end
        while (scl_oe === 1'b1) begin
            @(posedge sys_clk);
            lo++;
        end
        chk(hi, 8'h08);
        chk(lo, 8'h0c);
        wait_ev(8'h18);
        repeat (40) @(posedge sys_clk);
        chk({7'h00, scl_oe}, 8'h01);
        send(8'h56, 8'h20);
        send(8'h55, 8'h40);
        wr(8'hd8, 8'h44);
        wait_ev(8'h50);
        rd(8'hda, q);
        chk(q, 8'hff);
        send(8'h54, 8'h18);
        wr(8'hda, 8'ha5);
        wr(8'hd8, 8'h40);
        wait_ev(8'h30);
        wr(8'hd8, 8'h50);
        rd(8'hd9, q);
        chk(q, 8'hf8);
        n = 0;
        rd(8'hd8, q);
        while (q[4] !== 1'b0 && n < 600) begin
            rd(8'hd8, q);
            n++;
        end
        chk(q & 8'h18, 8'h00);
        chk({6'h00, scl_line, sda_line}, 8'h03);
        $display("transfers done");
        wr(8'hd8, 8'h61);
        repeat (100) @(posedge sys_clk);
        rd(8'hd8, q);
        chk(q & 8'h08, 8'h00);
        repeat (4) begin
            @(posedge sys_clk);
            ovf <= 1'b1;
            @(posedge sys_clk);
            ovf <= 1'b0;
        end
        wait_ev(8'h08);
        wr(8'hd8, 8'h00);
        repeat (4) @(posedge sys_clk);
        chk({6'h00, scl_oe, sda_oe}, 8'h00);
        $display("rate source done");
        summarize();
    end
endmodule : i2c_master_clock_and_modes_test
`default_nettype wire

// >>> sim/i2cm_slave_model.sv
// Purpose: behavioural i2c slave that acks one address
// Assumes: lines pulled up, model only ever pulls sda low
// Notes:   acks the first byte only and never returns data
`default_nettype none
module i2cm_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input  wire logic scl_i,
    input  wire logic sda_i,
    output var logic  sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] shift = 8'h00;
    int         nbit  = 0;
    initial sda_oe_o = 1'b0;
    // start or repeated start restarts byte framing
    always @(negedge sda_i) if (scl_i) nbit = 0;
    always @(posedge scl_i) shift = {shift[6:0], sda_i};
    // ack slot follows eight bits; released on the next fall
    always @(negedge scl_i) begin
        nbit = nbit + 1;
        sda_oe_o = (nbit == 9) && (shift[7:1] == ADDR);
    end
endmodule : i2cm_slave_model
`default_nettype wire
